// ### logic/wlx_pkg.sv
// Package: constants and carrier types for the word-load execution unit
package wlx_pkg;
	localparam int WLX_XLEN = 64;
	localparam int WLX_PA_W = 32;
	localparam int WLX_IMM_SHIFT = 16;
	localparam logic [2:0] WLX_ACC_WORD = 3'h3;
	localparam logic [1:0] WLX_UNIT_SYSCTL = 2'h0;
	localparam logic [63:0] WLX_DATA_RST = 64'h0;
	localparam logic [WLX_PA_W-1:0] WLX_PA_RST = 32'h0;

	typedef enum logic [2:0] {
		WLX_OP_UPPER_IMM,
		WLX_OP_WORD,
		WLX_OP_COP_WORD,
		WLX_OP_LEFT,
		WLX_OP_RIGHT
	} wlx_op_e;

	typedef struct packed {
		wlx_op_e op;
		logic [1:0] unit;
		logic [4:0] dest;
		logic [15:0] offset;
		logic [63:0] base;
		logic [63:0] dest_old;
	} wlx_req_s;

	typedef struct packed {
		logic [WLX_PA_W-1:0] paddr;
		logic uncached;
		logic [2:0] acc_type;
		logic [31:0] vaddr_lo;
	} wlx_mem_req_s;

	typedef struct packed {
		logic addr_err;
		logic bus_err;
		logic cop_unusable;
		logic reserved_instr;
	} wlx_exc_s;
endpackage

// ### logic/wlx_word_load_unit.sv
// Word-load execution unit: address formation, translation, memory read and merge
`timescale 1ns/1ps
`default_nettype none

module wlx_word_load_unit
	import wlx_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Instruction request
	input wire logic i_req_valid,
	input wire wlx_req_s i_req,
	output logic o_req_ready,
	// Endianness settings
	input wire logic i_processor_big_endian_setting,
	input wire logic i_memory_big_endian_setting,
	input wire logic i_reverse_endian_setting,
	// Coprocessor usable bits
	input wire logic [3:0] i_cop_usable,
	// Address translation
	output logic o_xlat_valid,
	output logic [63:0] o_xlat_vaddr,
	input wire logic i_xlat_done,
	input wire logic [WLX_PA_W-1:0] i_xlat_paddr,
	input wire logic i_xlat_uncached,
	// Memory read
	output logic o_mem_valid,
	output wlx_mem_req_s o_mem_req,
	input wire logic i_mem_done,
	input wire logic i_mem_bus_err,
	input wire logic [63:0] i_mem_rdata,
	// Register writeback
	output logic o_wb_valid,
	output logic [4:0] o_wb_dest,
	output logic [63:0] o_wb_data,
	// Coprocessor data
	output logic o_cop_valid,
	output logic [1:0] o_cop_unit,
	output logic [4:0] o_cop_dest,
	output logic [31:0] o_cop_data,
	// Exceptions
	output logic o_exc_valid,
	output wlx_exc_s o_exc
);

	typedef enum logic [2:0] {
		WLX_ST_IDLE,
		WLX_ST_XLAT,
		WLX_ST_MEM,
		WLX_ST_DONE
	} wlx_state_e;

	function automatic logic [63:0] wlx_sext32(input logic [31:0] w);
		wlx_sext32 = {{32{w[31]}}, w};
	endfunction

	function automatic logic wlx_is_partial(input wlx_op_e op);
		wlx_is_partial = (op == WLX_OP_LEFT) || (op == WLX_OP_RIGHT);
	endfunction

	wlx_state_e state_reg;
	wlx_req_s req_reg;
	logic [63:0] vaddr_reg;
	logic [63:0] vaddr_next;
	logic [63:0] dest_eff;
	logic [1:0] byte_sel;
	logic word_sel;
	logic [2:0] pa_low;
	logic [2:0] acc_type;
	logic [31:0] mem_word;
	logic [31:0] merged;
	logic align_err;
	logic cop_bad;
	logic cop_unuse;
	logic [5:0] lsh;
	logic [5:0] rsh;
	logic [31:0] lmask;
	logic [31:0] rmask;
	logic last_wb_valid_reg;
	logic [4:0] last_wb_dest_reg;
	logic [63:0] last_wb_data_reg;
	logic byp_reg;

	assign vaddr_next = {{48{i_req.offset[15]}}, i_req.offset} + i_req.base;

	// Bypass from the load written back just before this request
	assign dest_eff = byp_reg ? last_wb_data_reg : req_reg.dest_old;

	assign byte_sel = vaddr_reg[1:0] ^ {2{i_processor_big_endian_setting}};
	assign word_sel = vaddr_reg[2] ^ i_processor_big_endian_setting;
	assign mem_word = word_sel ? i_mem_rdata[63:32] : i_mem_rdata[31:0];
	assign align_err = (vaddr_reg[1:0] != 2'h0) && !wlx_is_partial(req_reg.op);
	assign cop_bad = (req_reg.op == WLX_OP_COP_WORD) && (req_reg.unit == WLX_UNIT_SYSCTL);
	assign cop_unuse = (req_reg.op == WLX_OP_COP_WORD) && !i_cop_usable[req_reg.unit];

	// Byte count minus one for partial loads, full word otherwise
	always_comb begin
		if (req_reg.op == WLX_OP_LEFT) begin
			acc_type = {1'b0, byte_sel};
		end else if (req_reg.op == WLX_OP_RIGHT) begin
			acc_type = {1'b0, ~byte_sel};
		end else begin
			acc_type = WLX_ACC_WORD;
		end
	end

	// Low physical bits after reverse endian and memory endianness
	always_comb begin
		pa_low = i_xlat_paddr[2:0] ^ {3{i_reverse_endian_setting}};
		if (req_reg.op == WLX_OP_LEFT && !i_memory_big_endian_setting) begin
			pa_low = pa_low & 3'h4;
		end else if (req_reg.op == WLX_OP_RIGHT && i_memory_big_endian_setting) begin
			pa_low = pa_low & 3'h4;
		end else if (!wlx_is_partial(req_reg.op)) begin
			pa_low = {pa_low[2], 2'h0};
		end
	end

	// Byte merge for partial loads
	always_comb begin
		lsh = 6'(5'd24 - {byte_sel, 3'h0});
		rsh = 6'({byte_sel, 3'h0});
		lmask = 32'hffffffff << lsh;
		rmask = 32'hffffffff >> rsh;
		merged = mem_word;
		if (req_reg.op == WLX_OP_LEFT) begin
			merged = ((mem_word << lsh) & lmask) | (dest_eff[31:0] & ~lmask);
		end else if (req_reg.op == WLX_OP_RIGHT) begin
			merged = ((mem_word >> rsh) & rmask) | (dest_eff[31:0] & ~rmask);
		end
	end

	// Request ready, high exactly while the sequencer idles
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_req_ready <= 1'b1;
		end else begin
			case (state_reg)
				WLX_ST_IDLE: o_req_ready <= !i_req_valid;
				WLX_ST_DONE: o_req_ready <= 1'b1;
				default: o_req_ready <= 1'b0;
			endcase
		end
	end

	// Sequencer
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= WLX_ST_IDLE;
		end else begin
			case (state_reg)
				WLX_ST_IDLE: begin
					if (i_req_valid) begin
						state_reg <= (i_req.op == WLX_OP_UPPER_IMM) ? WLX_ST_DONE : WLX_ST_XLAT;
					end
				end
				WLX_ST_XLAT: begin
					if (align_err || cop_bad || cop_unuse) begin
						state_reg <= WLX_ST_DONE;
					end else if (i_xlat_done) begin
						state_reg <= WLX_ST_MEM;
					end
				end
				WLX_ST_MEM: begin
					if (i_mem_done) begin
						state_reg <= WLX_ST_DONE;
					end
				end
				WLX_ST_DONE: state_reg <= WLX_ST_IDLE;
				default: state_reg <= WLX_ST_IDLE;
			endcase
		end
	end

	// Request capture
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			req_reg <= '0;
			vaddr_reg <= WLX_DATA_RST;
			byp_reg <= 1'b0;
		end else if (state_reg == WLX_ST_IDLE && i_req_valid) begin
			req_reg <= i_req;
			vaddr_reg <= vaddr_next;
			byp_reg <= last_wb_valid_reg && (last_wb_dest_reg == i_req.dest);
		end
	end

	// Translation request
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_xlat_valid <= 1'b0;
			o_xlat_vaddr <= WLX_DATA_RST;
		end else begin
			o_xlat_valid <= (state_reg == WLX_ST_IDLE && i_req_valid && i_req.op != WLX_OP_UPPER_IMM);
			if (state_reg == WLX_ST_IDLE && i_req_valid) begin
				o_xlat_vaddr <= vaddr_next;
			end
		end
	end

	// Memory read issue, only after translation
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mem_valid <= 1'b0;
			o_mem_req <= '0;
		end else begin
			o_mem_valid <= (state_reg == WLX_ST_XLAT) && i_xlat_done && !(align_err || cop_bad || cop_unuse);
			if (state_reg == WLX_ST_XLAT && i_xlat_done) begin
				o_mem_req.paddr <= {i_xlat_paddr[WLX_PA_W-1:3], pa_low};
				o_mem_req.uncached <= i_xlat_uncached;
				o_mem_req.acc_type <= acc_type;
				o_mem_req.vaddr_lo <= vaddr_reg[31:0];
			end
		end
	end

	// Writeback, coprocessor data and exceptions
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wb_valid <= 1'b0;
			o_wb_dest <= 5'h0;
			o_wb_data <= WLX_DATA_RST;
			o_cop_valid <= 1'b0;
			o_cop_unit <= 2'h0;
			o_cop_dest <= 5'h0;
			o_cop_data <= 32'h0;
			o_exc_valid <= 1'b0;
			o_exc <= '0;
		end else begin
			o_wb_valid <= 1'b0;
			o_cop_valid <= 1'b0;
			o_exc_valid <= 1'b0;
			o_exc <= '0;
			if (state_reg == WLX_ST_IDLE && i_req_valid && i_req.op == WLX_OP_UPPER_IMM) begin
				o_wb_valid <= 1'b1;
				o_wb_dest <= i_req.dest;
				o_wb_data <= wlx_sext32({i_req.offset, 16'h0});
			end else if (state_reg == WLX_ST_XLAT && (align_err || cop_bad || cop_unuse)) begin
				o_exc_valid <= 1'b1;
				o_exc.addr_err <= align_err && !cop_bad && !cop_unuse;
				o_exc.reserved_instr <= cop_bad;
				o_exc.cop_unusable <= cop_unuse && !cop_bad;
			end else if (state_reg == WLX_ST_MEM && i_mem_done) begin
				if (i_mem_bus_err) begin
					o_exc_valid <= 1'b1;
					o_exc.bus_err <= 1'b1;
				end else if (req_reg.op == WLX_OP_COP_WORD) begin
					o_cop_valid <= 1'b1;
					o_cop_unit <= req_reg.unit;
					o_cop_dest <= req_reg.dest;
					o_cop_data <= mem_word;
				end else begin
					o_wb_valid <= 1'b1;
					o_wb_dest <= req_reg.dest;
					o_wb_data <= wlx_sext32(merged);
				end
			end
		end
	end

	// Last writeback kept for the bypass
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			last_wb_valid_reg <= 1'b0;
			last_wb_dest_reg <= 5'h0;
			last_wb_data_reg <= WLX_DATA_RST;
		end else if (o_wb_valid) begin
			last_wb_valid_reg <= 1'b1;
			last_wb_dest_reg <= o_wb_dest;
			last_wb_data_reg <= o_wb_data;
		end else if (state_reg == WLX_ST_IDLE && i_req_valid) begin
			last_wb_valid_reg <= 1'b0;
		end
	end

	property p_upper_imm;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state_reg == WLX_ST_IDLE && i_req_valid && i_req.op == WLX_OP_UPPER_IMM) |=>
		(o_wb_valid && o_wb_data[15:0] == 16'h0 && o_wb_data[63:32] == {32{o_wb_data[31]}});
	endproperty
	a_upper_imm: assert property (p_upper_imm) else $error("upper immediate result wrong");

	property p_vaddr;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state_reg == WLX_ST_IDLE && i_req_valid && i_req.op != WLX_OP_UPPER_IMM) |=>
		(o_xlat_valid && o_xlat_vaddr == $past(i_req.base) + {{48{$past(i_req.offset[15])}}, $past(i_req.offset)});
	endproperty
	a_vaddr: assert property (p_vaddr) else $error("virtual address wrong");

	property p_mem_after_xlat;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(o_mem_valid) |-> $past(i_xlat_done) && $past(state_reg == WLX_ST_XLAT);
	endproperty
	a_mem_after_xlat: assert property (p_mem_after_xlat) else $error("read issued before translation");

	property p_sext;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_wb_valid |-> o_wb_data[63:32] == {32{o_wb_data[31]}};
	endproperty
	a_sext: assert property (p_sext) else $error("writeback not sign-extended");

	property p_align;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state_reg == WLX_ST_XLAT && !wlx_is_partial(req_reg.op) && vaddr_reg[1:0] != 2'h0
			&& !cop_bad && !cop_unuse) |=> (o_exc_valid && o_exc.addr_err && !o_mem_valid);
	endproperty
	a_align: assert property (p_align) else $error("missing address error");

	property p_no_partial_align;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state_reg == WLX_ST_XLAT && wlx_is_partial(req_reg.op)) |=> !o_exc.addr_err;
	endproperty
	a_no_partial_align: assert property (p_no_partial_align) else $error("partial load alignment error");

	property p_sysctl;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state_reg == WLX_ST_XLAT && cop_bad) |=> (o_exc_valid && o_exc.reserved_instr && !o_cop_valid);
	endproperty
	a_sysctl: assert property (p_sysctl) else $error("system control unit load accepted");

	property p_bus_err;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state_reg == WLX_ST_MEM && i_mem_done && i_mem_bus_err) |=> (o_exc.bus_err && !o_wb_valid);
	endproperty
	a_bus_err: assert property (p_bus_err) else $error("bus error not raised");

	c_word: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_wb_valid && req_reg.op == WLX_OP_WORD);
	c_left: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_wb_valid && req_reg.op == WLX_OP_LEFT);
	c_cop: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_cop_valid);

endmodule // wlx_word_load_unit

`default_nettype wire

// ### test/wlx_mem_model.sv
// Translation and memory partner model for the word-load unit
`timescale 1ns/1ps
`default_nettype none
module wlx_mem_model
	import wlx_pkg::*;
(
	// Clock and bench control
	input wire logic i_sys_clk,
	input wire logic i_slow,
	input wire logic i_bus_err,
	// Translation
	input wire logic i_xlat_valid,
	input wire logic [63:0] i_xlat_vaddr,
	output logic o_xlat_done,
	output logic [WLX_PA_W-1:0] o_xlat_paddr,
	output logic o_xlat_uncached,
	// Memory read
	input wire logic i_mem_valid,
	input wire wlx_mem_req_s i_mem_req,
	output logic o_mem_done,
	output logic o_mem_bus_err,
	output logic [63:0] o_mem_rdata
);
	logic [28:0] dw;
	initial begin
		o_xlat_done = 1'b0;
		o_xlat_paddr = 32'h0;
		o_xlat_uncached = 1'b0;
		o_mem_done = 1'b0;
		o_mem_bus_err = 1'b0;
		o_mem_rdata = 64'h0;
		forever begin
			@(posedge i_sys_clk);
			if (i_xlat_valid) begin
				repeat (i_slow ? 3 : 0) @(posedge i_sys_clk);
				#1 o_xlat_done = 1'b1;
				o_xlat_paddr = i_xlat_vaddr[31:0];
				o_xlat_uncached = i_xlat_vaddr[3];
				@(posedge i_sys_clk);
				#1 o_xlat_done = 1'b0;
				o_xlat_paddr = ~o_xlat_paddr;
				o_xlat_uncached = ~o_xlat_uncached;
			end else if (i_mem_valid) begin
				dw = i_mem_req.paddr[31:3];
				repeat (i_slow ? 2 : 0) @(posedge i_sys_clk);
				#1 o_mem_done = 1'b1;
				o_mem_bus_err = i_bus_err;
				o_mem_rdata = {dw, 3'h5, ~dw, 3'h2};
				@(posedge i_sys_clk);
				#1 o_mem_done = 1'b0;
				o_mem_bus_err = 1'b0;
				o_mem_rdata = ~o_mem_rdata;
			end
		end
	end
endmodule // wlx_mem_model
`default_nettype wire

// ### test/wlx_word_load_unit_tb.sv
// Self-checking bench for the word-load execution unit
`timescale 1ns/1ps
`default_nettype none
module wlx_word_load_unit_tb
	import wlx_pkg::*;
;
	logic clk, rst_b, rv, rdy, pbe, mbe, re, slow, berr, xv, xd, xu, mv, md, mb;
	logic wv, cv, ev, g_wb, g_cop, g_exc, g_mem, g_xl;
	logic [3:0] us;
	logic [63:0] xva, mrd, wd, c_va;
	logic [31:0] xpa, cd;
	logic [4:0] wdst, cdst;
	logic [1:0] cu;
	wlx_req_s req, r;
	wlx_mem_req_s mq, c_mem;
	wlx_exc_s ex, c_exc;
	logic [63:0] regs [32];
	int failures, cmp_count, i;
	wlx_word_load_unit u_wlx_word_load_unit(.i_sys_clk(clk), .i_rst_b(rst_b), .i_req_valid(rv), .i_req(req),
		.o_req_ready(rdy), .i_processor_big_endian_setting(pbe), .i_memory_big_endian_setting(mbe),
		.i_reverse_endian_setting(re), .i_cop_usable(us), .o_xlat_valid(xv), .o_xlat_vaddr(xva),
		.i_xlat_done(xd), .i_xlat_paddr(xpa), .i_xlat_uncached(xu), .o_mem_valid(mv), .o_mem_req(mq),
		.i_mem_done(md), .i_mem_bus_err(mb), .i_mem_rdata(mrd), .o_wb_valid(wv), .o_wb_dest(wdst),
		.o_wb_data(wd), .o_cop_valid(cv), .o_cop_unit(cu), .o_cop_dest(cdst), .o_cop_data(cd),
		.o_exc_valid(ev), .o_exc(ex));
	wlx_mem_model u_wlx_mem_model(.i_sys_clk(clk), .i_slow(slow), .i_bus_err(berr), .i_xlat_valid(xv),
		.i_xlat_vaddr(xva), .o_xlat_done(xd), .o_xlat_paddr(xpa), .o_xlat_uncached(xu), .i_mem_valid(mv),
		.i_mem_req(mq), .o_mem_done(md), .o_mem_bus_err(mb), .o_mem_rdata(mrd));
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (wv) g_wb <= 1'b1;
		if (cv) g_cop <= 1'b1;
		if (ev) g_exc <= 1'b1;
		if (xv) g_xl <= 1'b1;
		if (xv) c_va <= xva;
		if (mv) g_mem <= 1'b1;
		if (mv) c_mem <= mq;
		if (ev) c_exc <= ex;
	end
	task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
		cmp_count++;
		if (e !== g) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic wlx_req_s mk(wlx_op_e op, logic [1:0] u, logic [4:0] d, logic [15:0] o, logic [63:0] b);
		mk = {op, u, d, o, b, regs[d]};
	endfunction
	task automatic run_op(input wlx_req_s q, input logic be, input logic rev, input logic [3:0] usb, input logic be_err);
		logic [63:0] va, dw;
		logic [31:0] w, m, old;
		logic [1:0] b;
		logic [2:0] acc, pl;
		wlx_exc_s x;
		logic mw, ew, ec;
		int n;
		va = {{48{q.offset[15]}}, q.offset} + q.base;
		dw = {va[31:3], 3'h5, ~va[31:3], 3'h2};
		w = (va[2] ^ be) ? dw[63:32] : dw[31:0];
		b = va[1:0] ^ {be, be};
		old = regs[q.dest][31:0];
		mw = (q.op == WLX_OP_WORD) || (q.op == WLX_OP_COP_WORD);
		x = '0;
		if (q.op == WLX_OP_COP_WORD && q.unit == WLX_UNIT_SYSCTL) x.reserved_instr = 1'b1;
		else if (q.op == WLX_OP_COP_WORD && !usb[q.unit]) x.cop_unusable = 1'b1;
		else if (mw && va[1:0] != 2'h0) x.addr_err = 1'b1;
		else if (mw && be_err) x.bus_err = 1'b1;
		m = w;
		acc = WLX_ACC_WORD;
		if (q.op == WLX_OP_UPPER_IMM) m = {q.offset, 16'h0};
		if (q.op == WLX_OP_LEFT) m = (w << (8 * (3 - b))) | (old & (32'hffffffff >> (8 * b + 8)));
		if (q.op == WLX_OP_LEFT) acc = {1'b0, b};
		if (q.op == WLX_OP_RIGHT) m = (w >> (8 * b)) | (old & ~(32'hffffffff >> (8 * b)));
		if (q.op == WLX_OP_RIGHT) acc = {1'b0, 2'h3 - b};
		pl = va[2:0] ^ {3{rev}};
		if (mw || ((q.op == WLX_OP_LEFT) ^ be ^ rev)) pl = pl & 3'h4;
		ew = (q.op != WLX_OP_COP_WORD) && (x == '0);
		ec = (q.op == WLX_OP_COP_WORD) && (x == '0);
		@(posedge clk);
		#1 {g_wb, g_cop, g_exc, g_mem, g_xl} = '0;
		c_exc = '0;
		req = q;
		pbe = be;
		re = rev;
		mbe = be ^ rev;
		us = usb;
		berr = be_err & mw;
		rv = 1'b1;
		@(posedge clk);
		#1 rv = 1'b0;
		n = 0;
		while (!(g_wb | g_cop | g_exc) && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		repeat (2) @(posedge clk);
		#1 check("outcome", {ew, ec, x != '0}, {g_wb, g_cop, g_exc});
		check("exc", x, c_exc);
		if (q.op == WLX_OP_UPPER_IMM) check("xlat", 64'h0, g_xl);
		else check("vaddr", va, c_va);
		if (x != '0 && !x.bus_err) check("mem", 64'h0, g_mem);
		else if (q.op != WLX_OP_UPPER_IMM) check("req", {va[31:3], va[3], acc}, {c_mem.paddr[31:3], c_mem.uncached, c_mem.acc_type});
		if (q.op != WLX_OP_UPPER_IMM && x == '0) check("lowpa", pl, c_mem.paddr[2:0]);
		if (q.op != WLX_OP_UPPER_IMM && (x == '0 || x.bus_err)) check("vlo", va[31:0], c_mem.vaddr_lo);
		if (ew) check("wbdata", {{32{m[31]}}, m}, wd);
		if (ew) check("wbdest", q.dest, wdst);
		if (ew) regs[q.dest] = {{32{m[31]}}, m};
		if (ec) check("cop", {q.unit, q.dest, w}, {cu, cdst, cd});
		n = 0;
		while (rdy !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#(25 * 30000);
		failures++;
		finish_test();
	end
	initial begin
		{clk, rst_b, rv, pbe, mbe, re, slow, berr, us, failures, cmp_count} = '0;
		req = '0;
		for (i = 0; i < 32; i++) regs[i] = 64'h0;
		void'($urandom(50221));
		repeat (20) @(posedge clk);
		#1 rst_b = 1'b1;
		run_op(mk(WLX_OP_UPPER_IMM, 2'h0, 5'h3, 16'h8001, 64'h0), 1'b0, 1'b0, 4'hf, 1'b0);
		run_op(mk(WLX_OP_UPPER_IMM, 2'h0, 5'h4, 16'h7ffe, 64'h5), 1'b1, 1'b0, 4'hf, 1'b0);
		$display("test upper_imm done");
		for (i = 0; i < 8; i++) run_op(mk(WLX_OP_WORD, 2'h0, 5'h5, 16'h8000 + 16'(i), 64'h1_2345_6780), i[0], i[1], 4'hf, 1'b0);
		run_op(mk(WLX_OP_WORD, 2'h0, 5'h6, 16'h10, 64'h1000), 1'b0, 1'b0, 4'hf, 1'b1);
		$display("test word done");
		for (i = 0; i < 16; i++) run_op(mk(WLX_OP_COP_WORD, i[1:0], 5'h7, {14'h0, i[3:2]}, 64'h2000), 1'b0, 1'b0, 4'b1011, 1'b0);
		run_op(mk(WLX_OP_COP_WORD, 2'h1, 5'h7, 16'h4, 64'h2000), 1'b1, 1'b0, 4'hf, 1'b1);
		$display("test cop done");
		for (i = 0; i < 32; i++) begin
			slow = i[4];
			run_op(mk(i[0] ? WLX_OP_RIGHT : WLX_OP_LEFT, 2'h0, 5'h8, {13'h0, i[3:1]}, 64'h3000), i[4], i[2], 4'hf, 1'b0);
		end
		$display("test partial done");
		run_op(mk(WLX_OP_WORD, 2'h0, 5'h9, 16'h0, 64'h4000), 1'b0, 1'b0, 4'hf, 1'b0);
		r = mk(WLX_OP_LEFT, 2'h0, 5'h9, 16'h11, 64'h4000);
		r.dest_old = ~r.dest_old;
		run_op(r, 1'b0, 1'b0, 4'hf, 1'b0);
		r = mk(WLX_OP_RIGHT, 2'h0, 5'h9, 16'h16, 64'h4000);
		r.dest_old = ~r.dest_old;
		run_op(r, 1'b0, 1'b0, 4'hf, 1'b0);
		$display("test bypass done");
		for (i = 0; i < 200; i++) begin
			slow = 1'($urandom);
			run_op(mk(wlx_op_e'($urandom_range(4)), 2'($urandom), 5'($urandom), 16'($urandom), {$urandom, $urandom}),
				1'($urandom), 1'($urandom), 4'($urandom), $urandom_range(7) == 0);
		end
		$display("test random done");
		finish_test();
	end
endmodule // wlx_word_load_unit_tb
`default_nettype wire
